// ---- twm_defs.vh ----
`ifndef TWM_DEFS_VH
`define TWM_DEFS_VH
// Register offsets.
`define TWM_OFF_ENABLE 12'h500
`define TWM_OFF_SDA_PSEL 12'h50c
`define TWM_OFF_RATE 12'h524
`define TWM_OFF_RX_PTR 12'h534
`define TWM_OFF_RX_MAX 12'h538
`define TWM_OFF_RX_AMT 12'h53c
`define TWM_OFF_RX_LIST 12'h540
`define TWM_OFF_TX_PTR 12'h544
`define TWM_OFF_TX_MAX 12'h548
`define TWM_OFF_TX_AMT 12'h54c
`define TWM_OFF_TX_LIST 12'h550
`define TWM_OFF_ADDR 12'h588
`define TWM_OFF_CTRL 12'h600
`define TWM_OFF_ERR 12'h604
`define TWM_OFF_MASK 12'h608
// Field values and reset values.
`define TWM_ENABLE_ON 4'h6
`define TWM_PSEL_RESET 32'h0fffffff
`define TWM_RATE_100K 32'h01980000
`define TWM_RATE_250K 32'h04000000
`define TWM_LIST_ARRAY 2'h1
// Half SCL period in cycles at 10 MHz: 5000 ns and 2000 ns halves.
`define TWM_HALF_100K 10'd50
`define TWM_HALF_250K 10'd20
// Status bit positions.
`define TWM_ST_ADDRESS_NACK_FLAG 0
`define TWM_ST_DATA_NACK_FLAG 1
`define TWM_ST_DONE 2
`endif

// ---- twm_master.v ----
`timescale 1ns/10ps
// Contract
// - The data-line pin select holds a 5-bit pin number and a connect bit where 1 disconnects and 0 connects.
// - Rate code 0x01980000 gives 100 kbps and 0x04000000 gives 250 kbps on SCL.
// - The SCL rate is divided from the system clock so its accuracy follows that clock.
// - Receive stores no more bytes than the receive maximum count.
// - Transmit fetches and sends no more bytes than the transmit maximum count.
// - Each channel reports bytes moved in the last transaction as a read-only 10-bit count.
// - On a not-acknowledge the count includes the refused byte.
// - List type 0 disables list handling and 1 selects array list, for both channels; the code only stores and reads back the field.
// - The address register supplies the slave address of every transfer.
// - The master starts transfers and connects SDA only while its enable field holds 6.
// - Address and data not-acknowledge set separate flags, cleared by writing 1.
`include "twm_defs.vh"
module twm_master (
  input wire clk_i,
  input wire rst_b_i,
  input wire [11:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg irq_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg [31:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_o,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  output reg [4:0] sda_pin_o,
  output reg sda_connect_o
);
  // ****************************************
  // Reset synchroniser
  // ****************************************
  reg rst_s1;
  reg rst_s2;
  // Release is delayed two clocks so no flop leaves reset on a half edge.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst_b = rst_s2;

  // ****************************************
  // Registers
  // ****************************************
  reg [3:0] enable;
  reg [31:0] sda_psel;
  reg [31:0] rate;
  reg [31:0] rx_ptr;
  reg [9:0] rx_max;
  reg [9:0] rx_amt;
  reg [1:0] rx_list;
  reg [31:0] tx_ptr;
  reg [9:0] tx_max;
  reg [9:0] tx_amt;
  reg [1:0] tx_list;
  reg [6:0] slave_addr;
  reg [2:0] status;
  reg [2:0] mask;
  reg [2:0] ev;
  reg busy;
  reg dir_rx;
  wire start_tx = wr_i && addr_i == `TWM_OFF_CTRL && wdata_i[0];
  wire start_rx = wr_i && addr_i == `TWM_OFF_CTRL && wdata_i[1];
  wire active = (enable == `TWM_ENABLE_ON);

  // Register writes; pointers are full byte addresses.
  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      enable <= 4'h0;
      sda_psel <= `TWM_PSEL_RESET;
      rate <= `TWM_RATE_250K;
      rx_ptr <= 32'h00000000;
      rx_max <= 10'h000;
      rx_list <= 2'h0;
      tx_ptr <= 32'h00000000;
      tx_max <= 10'h000;
      tx_list <= 2'h0;
      slave_addr <= 7'h00;
      mask <= 3'h0;
    end else if (wr_i) begin
      case (addr_i)
        `TWM_OFF_ENABLE: enable <= wdata_i[3:0];
        `TWM_OFF_SDA_PSEL: sda_psel <= {wdata_i[31], 26'h3ffffff, wdata_i[4:0]};
        `TWM_OFF_RATE: rate <= wdata_i;
        `TWM_OFF_RX_PTR: rx_ptr <= wdata_i;
        `TWM_OFF_RX_MAX: rx_max <= wdata_i[9:0];
        `TWM_OFF_RX_LIST: rx_list <= wdata_i[1:0];
        `TWM_OFF_TX_PTR: tx_ptr <= wdata_i;
        `TWM_OFF_TX_MAX: tx_max <= wdata_i[9:0];
        `TWM_OFF_TX_LIST: tx_list <= wdata_i[1:0];
        `TWM_OFF_ADDR: slave_addr <= wdata_i[6:0];
        `TWM_OFF_MASK: mask <= wdata_i[2:0];
        default: enable <= enable;
      endcase
    end
  end

  // Sticky status; a new event wins over a same-cycle clear.
  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~((wr_i && addr_i == `TWM_OFF_ERR) ? wdata_i[2:0] : 3'h0)) | ev;
    end
  end

  // Read port with one cycle latency, unmapped reads give zero.
  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rdata_o <= 32'h00000000;
      irq_o <= 1'b0;
      sda_pin_o <= 5'h1f;
      sda_connect_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
      sda_pin_o <= sda_psel[4:0];
      sda_connect_o <= ~sda_psel[31] & active;
      rdata_o <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          `TWM_OFF_ENABLE: rdata_o <= {28'h0000000, enable};
          `TWM_OFF_SDA_PSEL: rdata_o <= sda_psel;
          `TWM_OFF_RATE: rdata_o <= rate;
          `TWM_OFF_RX_PTR: rdata_o <= rx_ptr;
          `TWM_OFF_RX_MAX: rdata_o <= {22'h000000, rx_max};
          `TWM_OFF_RX_AMT: rdata_o <= {22'h000000, rx_amt};
          `TWM_OFF_RX_LIST: rdata_o <= {30'h00000000, rx_list};
          `TWM_OFF_TX_PTR: rdata_o <= tx_ptr;
          `TWM_OFF_TX_MAX: rdata_o <= {22'h000000, tx_max};
          `TWM_OFF_TX_AMT: rdata_o <= {22'h000000, tx_amt};
          `TWM_OFF_TX_LIST: rdata_o <= {30'h00000000, tx_list};
          `TWM_OFF_ADDR: rdata_o <= {25'h0000000, slave_addr};
          `TWM_OFF_CTRL: rdata_o <= {31'h00000000, busy};
          `TWM_OFF_ERR: rdata_o <= {29'h00000000, status};
          `TWM_OFF_MASK: rdata_o <= {29'h00000000, mask};
          default: rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // Bit engine
  // ****************************************
  // Unknown rate codes fall back to 250 kbps rather than stalling the bus.
  wire [9:0] half = (rate == `TWM_RATE_100K) ? `TWM_HALF_100K : `TWM_HALF_250K;
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_BIT = 3'd2;
  localparam S_ACK = 3'd3;
  localparam S_STOP = 3'd4;
  localparam S_FETCH = 3'd5;
  reg [2:0] state;
  reg [9:0] tick;
  reg phase;
  reg [3:0] bitn;
  reg [7:0] shreg;
  reg addr_phase;
  reg [9:0] count;
  reg [31:0] ptr;
  reg [9:0] limit;
  wire tick_end = (tick == half - 10'd1);

  // One phase is half an SCL period; SCL low in phase 0, released in phase 1.
  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      tick <= 10'h000;
      phase <= 1'b0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      addr_phase <= 1'b0;
      count <= 10'h000;
      ptr <= 32'h00000000;
      limit <= 10'h000;
      busy <= 1'b0;
      dir_rx <= 1'b0;
      ev <= 3'h0;
      rx_amt <= 10'h000;
      tx_amt <= 10'h000;
      scl_o <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= 32'h00000000;
      mem_wdata_o <= 8'h00;
    end else begin
      ev <= 3'h0;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      tick <= tick_end ? 10'h000 : tick + 10'd1;
      case (state)
        S_IDLE: begin
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
          tick <= 10'h000;
          if (active && (start_tx || start_rx)) begin
            busy <= 1'b1;
            dir_rx <= start_rx;
            ptr <= start_rx ? rx_ptr : tx_ptr;
            limit <= start_rx ? rx_max : tx_max;
            count <= 10'h000;
            shreg <= {slave_addr, start_rx};
            addr_phase <= 1'b1;
            bitn <= 4'h0;
            phase <= 1'b0;
            sda_oe_o <= 1'b1; // Start: SDA low while SCL is high.
            state <= S_START;
          end
        end
        S_START: if (tick_end) begin
          scl_oe_o <= 1'b1;
          state <= S_BIT;
        end
        S_BIT: begin
          // SDA moves a cycle after SCL has fallen and holds through the high half,
          // so an SDA edge never meets a high SCL and reads as a start or a stop.
          if (!phase) begin
            sda_oe_o <= (dir_rx && !addr_phase) ? 1'b0 : ~shreg[7];
          end
          if (tick_end) begin
            phase <= ~phase;
            scl_oe_o <= phase;
            if (phase) begin
              shreg <= {shreg[6:0], sda_i};
              if (bitn == 4'd7) begin
                bitn <= 4'h0;
                state <= S_ACK;
              end else begin
                bitn <= bitn + 4'd1;
              end
            end
          end
        end
        S_ACK: begin
          if (!phase) begin
            // Receiver acks every byte except the last one it will store.
            sda_oe_o <= dir_rx && !addr_phase && (count + 10'd1 < limit);
          end
          if (tick_end) begin
            phase <= ~phase;
            scl_oe_o <= phase;
          end
          // The acknowledge is read at the end of the high half, as SCL falls.
          if (tick_end && phase) begin
            if (dir_rx && !addr_phase) begin
              mem_wr_o <= 1'b1;
              mem_addr_o <= ptr;
              mem_wdata_o <= shreg;
              ptr <= ptr + 32'd1;
              count <= count + 10'd1;
              state <= (count + 10'd1 < limit) ? S_BIT : S_STOP;
            end else if (sda_i) begin
              ev <= addr_phase ? 3'b001 : 3'b010;
              if (!addr_phase) count <= count + 10'd1;
              state <= S_STOP;
            end else begin
              if (!addr_phase) count <= count + 10'd1;
              addr_phase <= 1'b0;
              if (dir_rx ? (limit == 10'h000) : (count + (addr_phase ? 10'd0 : 10'd1) >= limit)) begin
                state <= S_STOP;
              end else begin
                state <= dir_rx ? S_BIT : S_FETCH;
              end
            end
          end
        end
        S_FETCH: begin
          mem_rd_o <= !mem_rd_o && tick == 10'h000;
          mem_addr_o <= ptr;
          if (tick == 10'd2) begin
            shreg <= mem_rdata_i;
            ptr <= ptr + 32'd1;
            state <= S_BIT;
          end
        end
        S_STOP: begin
          // SDA is pulled low while SCL is still low; releasing it with SCL high makes the stop.
          if (!phase) begin
            sda_oe_o <= 1'b1;
          end
          if (tick_end) begin
            phase <= ~phase;
            if (!phase) begin
              scl_oe_o <= 1'b0;
            end else begin
              sda_oe_o <= 1'b0;
              busy <= 1'b0;
              ev <= 3'b100;
              if (dir_rx) rx_amt <= count;
              else tx_amt <= count;
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- twm_sva.sv ----
`timescale 1ns/10ps
// ****
// Checker on the master's ports.
// ****
module twm_sva (
  input wire clk_i,
  input wire rst_b_i,
  input wire [11:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire mem_rd_o,
  input wire mem_wr_o,
  input wire scl_oe_o,
  input wire sda_connect_o
);
  reg [9:0] rxm, txm, nw, nr, lo;
  reg [31:0] rxp;
  reg en, slow;
  // Shadows of bus writes; a start clears the moved-byte counters.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {rxm, txm, nw, nr, lo, rxp, en, slow} <= 84'h0;
    end else begin
      if (wr_i && addr_i == 12'h538) rxm <= wdata_i[9:0];
      if (wr_i && addr_i == 12'h548) txm <= wdata_i[9:0];
      if (wr_i && addr_i == 12'h534) rxp <= wdata_i;
      if (wr_i && addr_i == 12'h500) en <= wdata_i[3:0] == 4'h6;
      if (wr_i && addr_i == 12'h524) slow <= wdata_i == 32'h01980000;
      nw <= (wr_i && addr_i == 12'h600) ? 10'h0 : nw + mem_wr_o;
      nr <= (wr_i && addr_i == 12'h600) ? 10'h0 : nr + mem_rd_o;
      lo <= scl_oe_o ? lo + 10'h1 : 10'h0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence ptr_rd;
    rd_i && addr_i == 12'h534;
  endsequence
  rx_ptr_a: assert property (ptr_rd |=> rdata_o == rxp) else $error("pointer readback wrong");
  rx_amount_a: assert property (rd_i && addr_i == 12'h53c |=> rdata_o[31:10] == 22'h0) else $error("rx count wide");
  tx_amount_a: assert property (rd_i && addr_i == 12'h54c |=> rdata_o[31:10] == 22'h0) else $error("tx count wide");
  list_field_a: assert property (rd_i && addr_i == 12'h540 |=> rdata_o[31:2] == 30'h0) else $error("list wide");
  rx_bound_a: assert property (mem_wr_o |-> nw < rxm) else $error("too many bytes stored");
  tx_bound_a: assert property (mem_rd_o |-> nr < txm) else $error("too many bytes fetched");
  off_quiet_a: assert property (!en |-> !scl_oe_o && !mem_rd_o) else $error("active while disabled");
  scl_low_a: assert property ($fell(scl_oe_o) |-> lo >= (slow ? 10'd40 : 10'd16)) else $error("scl low short");
  disconnect_a: assert property (wr_i && addr_i == 12'h50c && wdata_i[31] |-> ##[1:3] !sda_connect_o)
    else $error("data line still connected");
endmodule
bind twm_master twm_sva i_twm_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .scl_oe_o(scl_oe_o), .sda_connect_o(sda_connect_o));

// ---- twm_slave.sv ----
`timescale 1ns/10ps
// ****
// Two-wire slave: acks unless told to refuse byte nack_i.
// ****
module twm_slave (
  input wire scl_i,
  input wire sda_i,
  input wire [7:0] nack_i,
  output reg pull_o,
  output reg [7:0] addr_o,
  output reg [7:0] got_o,
  output reg [7:0] last_o
);
  reg [7:0] sh, d;
  reg live, rd, mack;
  integer n, b;
  initial begin
    {pull_o, addr_o, got_o, last_o, live, rd, mack, sh, d} = 0;
  end
  // Start and stop are data edges while the clock is high.
  always @(negedge sda_i) if (scl_i === 1'b1) {live, n, b, got_o} = {1'b1, 72'h0};
  always @(posedge sda_i) if (scl_i === 1'b1) live = 1'b0;
  always @(posedge scl_i) if (live) begin
    if (n < 8) {sh, n} = {sh[6:0], sda_i, n + 1};
    else mack = sda_i;
  end
  // Data changes only while the clock is low.
  always @(negedge scl_i) if (live) begin
    if (n == 8) begin
      if (b == 0) {addr_o, rd} = {sh, sh[0]};
      if (b > 0 && !rd) {got_o, last_o} = {got_o + 8'h1, sh};
      pull_o = (b == 0 || !rd) && b != nack_i;
      n = 9;
    end else if (n == 9) begin
      if ((b == 0 || !rd) ? b == nack_i : mack) {live, pull_o} = 2'h0;
      else begin
        {b, n} = {b + 1, 32'h0};
        d = 8'ha0 + b;
        pull_o = rd && !d[7];
      end
    end else if (rd && b > 0) pull_o = !d[7 - n];
  end
endmodule

// ---- twm_master_test.sv ----
`timescale 1ns/10ps
// ****
// Register-level tests of the master.
// ****
module twm_master_test;
  reg clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [11:0] addr = 12'h0;
  reg [31:0] wdata = 32'h0, rv, wa;
  reg [7:0] mrd = 8'h0, nack = 8'hff, wd;
  integer bad_count = 0, checks_done = 0;
  wire [31:0] rdata, maddr;
  wire [7:0] mwd, s_addr, s_got, s_last;
  wire [4:0] pin;
  wire irq, mr, mw, scl, scl_oe, sda, sda_oe, conn, pull;
  // Pulled-up open-drain lines.
  wire scl_w = !scl_oe;
  wire sda_w = !(sda_oe || pull);
  initial begin
    forever #50 clk = ~clk;
  end
  twm_master i_twm_master (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq), .mem_rd_o(mr), .mem_wr_o(mw), .mem_addr_o(maddr), .mem_wdata_o(mwd),
    .mem_rdata_i(mrd), .scl_i(scl_w), .scl_o(scl), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda),
    .sda_oe_o(sda_oe), .sda_pin_o(pin), .sda_connect_o(conn));
  twm_slave i_twm_slave (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack), .pull_o(pull), .addr_o(s_addr),
    .got_o(s_got), .last_o(s_last));
  // Buffer memory: data registered one cycle after the address, so it is ready two edges after the fetch strobe.
  always @(posedge clk) begin
    mrd <= maddr[7:0] + 8'h30;
    if (mw) {wa, wd} <= {maddr, mwd};
  end
  task chk(input string n, input [31:0] e, input [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task w(input [11:0] a, input [31:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task r(input [11:0] a, input [31:0] e);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
    chk($sformatf("reg %h", a), e, rv);
  endtask
  // Start with only the done bit unmasked, so the wait ends after the stop, not at an early error flag.
  task run(input [31:0] go, input [31:0] st);
    integer k;
    w(12'h608, 32'h4);
    w(12'h600, go);
    for (k = 0; k < 20000 && irq !== 1'b1; k = k + 1) @(posedge clk);
    chk("done irq", 1, irq);
    w(12'h608, 32'h0);
    repeat (2) @(posedge clk);
    chk("masked irq", 0, irq);
    w(12'h608, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    r(12'h604, st | 32'h4);
    w(12'h604, 32'h7);
    r(12'h604, 32'h0);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    r(12'h50c, 32'h0fffffff);
    r(12'h524, 32'h04000000);
    r(12'h53c, 32'h0);
    r(12'h7fc, 32'h0);
    w(12'h550, 32'h1);
    r(12'h550, 32'h1);
    w(12'h54c, 32'h5);
    r(12'h54c, 32'h0);
    w(12'h50c, 32'ha);
    w(12'h500, 32'h6);
    w(12'h588, 32'h2a);
    w(12'h534, 32'h20000100);
    w(12'h544, 32'h20000040);
    w(12'h548, 32'h2);
    r(12'h534, 32'h20000100);
    chk("pin", 5'ha, pin);
    chk("connect", 1, conn);
    run(32'h1, 32'h0);
    chk("slave address", 8'h54, s_addr);
    chk("bytes sent", 2, s_got);
    chk("last sent", 8'h71, s_last);
    chk("open drain", 0, {scl, sda});
    r(12'h54c, 32'h2);
    nack <= 8'h1;
    w(12'h548, 32'h3);
    run(32'h1, 32'h2);
    r(12'h54c, 32'h1);
    chk("refused byte", 8'h70, s_last);
    nack <= 8'hff;
    w(12'h524, 32'h01980000);
    w(12'h538, 32'h2);
    run(32'h2, 32'h0);
    r(12'h53c, 32'h2);
    chk("last byte", 8'ha2, wd);
    chk("last place", 32'h20000101, wa);
    chk("slave address", 8'h55, s_addr);
    nack <= 8'h0;
    run(32'h2, 32'h1);
    w(12'h50c, 32'h8000000a);
    w(12'h500, 32'h0);
    w(12'h600, 32'h1);
    r(12'h600, 32'h0);
    chk("connect", 0, conn);
    final_report;
  end
endmodule
